// *** fcr_defs.svh ***
`ifndef FCR_DEFS_SVH
`define FCR_DEFS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define FCR_ADDR_EXT_LO 12'h000
`define FCR_ADDR_EXT_HI 12'h004
`define FCR_ADDR_CHECK 12'h008
`define FCR_ADDR_STATUS 12'h00C

// ****************************************
// Field positions
// ****************************************
`define FCR_BIT_V86 0
`define FCR_BIT_PMV 1
`define FCR_BIT_TSR 2
`define FCR_BIT_DBG 3
`define FCR_BIT_LPG 4
`define FCR_BIT_PAX 5
`define FCR_BIT_MCX 6
`define FCR_BIT_GPE 7
`define FCR_BIT_CRD 8
`define FCR_BIT_OSF 9
`define FCR_BIT_OSX 10
`define FCR_DEF_BITS 11
`define FCR_DEF_MASK 64'h0000_0000_0000_07FF

// ****************************************
// Reset value and fixed constants
// ****************************************
`define FCR_EXT_RESET 64'h0000_0000_0000_0000
`define FCR_PERF_COUNT 3'h4
`define FCR_PHYS_BITS_EXT 6'h34
`define FCR_PHYS_BITS_LEG 6'h20

`endif

// *** fcr_pkg.sv ***
package fcr_pkg;

	// Instruction class presented to the check port
	typedef enum logic [3:0]
	{
		FCR_OP_NONE,
		FCR_OP_TS_READ,
		FCR_OP_TS_READ_AUX,
		FCR_OP_PERF_READ,
		FCR_OP_DBG_ACCESS,
		FCR_OP_MEDIA128,
		FCR_OP_FULL_SAVE,
		FCR_OP_SIMD_EXC,
		FCR_OP_MC_ERROR,
		FCR_OP_IRQ_SETCLR,
		FCR_OP_SW_IRQ
	} fcr_op_t;

	// Check request
	typedef struct packed
	{
		logic v86_mode;
		logic long_mode;
		logic correctable;
		logic [1:0] current_priv_level;
		logic [2:0] index;
		fcr_op_t op;
	} fcr_req_t;

	// Check verdict
	typedef struct packed
	{
		logic undefined_opcode_fault;
		logic machine_check_fault;
		logic simd_fp_fault;
		logic priv_fault;
		logic mc_record;
		logic use_virtual_irq;
		logic redirect_bitmap;
		logic [2:0] debug_target;
	} fcr_res_t;

	// Translation controls derived from the register
	typedef struct packed
	{
		logic entries_64;
		logic large_4m;
		logic large_2m;
		logic keep_global;
		logic io_breakpoints;
		logic [5:0] phys_bits;
	} fcr_xlate_t;

endpackage : fcr_pkg

// *** fcr_ctrl.sv ***
// What this block does
// - Legacy mode sees exactly the low 32 bits, same layout.
// - Bits 0 to 10 are all read/write.
// - Bit 0 virtualises irq flags in v86 and enables redirection bitmap.
// - Bit 1 makes only irq set/clear use virtual flags, also long mode.
// - Bit 2 set restricts timestamp reads to privilege 0.
// - Bit 3 set enables I/O breakpoints; debug 4/5 access faults.
// - Bit 3 clear aliases debug 4/5 onto 6/7, no I/O breakpoints.
// - Bit 4 set allows 4M pages per page size field, else 4K only.
// - Bit 4 ignored when address extension set, hence in long mode.
// - Bit 5 gives 64-bit entries, 52-bit addresses, 2M pages.
// - Bit 6 set: uncorrectable machine-check error raises machine check fault.
// - Errors are recorded regardless; correctable errors never fault.
// - Bit 7 keeps global translations on table base writes.
// - Global pages apply to every page size.
// - Bit 8 set allows counter reads at any level, else level 0.
// - Counter read reaches four counters, index 0 to 3.
// - Bit 9 clear faults 128-bit media ops; full save stays usable.
// - Bit 10 clear turns unmasked SIMD exceptions into undefined opcode.
`include "fcr_defs.svh"

module fcr_ctrl
	import fcr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core mode
	input wire logic legacy_mode,
	// Check port
	input wire logic chk_valid,
	input wire fcr_req_t chk_req,
	output logic chk_done,
	output fcr_res_t chk_res,
	// Translation controls
	output fcr_xlate_t xlate,
	output logic [63:0] extension_control
);

	// ****************************************
	// Register storage
	// ****************************************
	logic [63:0] ext_r;
	logic [63:0] ext_nxt;
	fcr_req_t req_r;
	logic req_valid_r;
	logic [7:0] fault_cnt_r;

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	wire logic wr_acc = psel && penable && pwrite;
	wire logic rd_setup = psel && !penable && !pwrite;
	wire logic addr_ok = (paddr == `FCR_ADDR_EXT_LO) || (paddr == `FCR_ADDR_EXT_HI)
		|| (paddr == `FCR_ADDR_CHECK) || (paddr == `FCR_ADDR_STATUS);

	always_comb
	begin
		ext_nxt = ext_r;
		if (wr_acc && paddr == `FCR_ADDR_EXT_LO)
		begin
			ext_nxt[31:0] = lane_merge(ext_r[31:0], pwdata, pstrb);
		end
		else if (wr_acc && paddr == `FCR_ADDR_EXT_HI && !legacy_mode)
		begin
			ext_nxt[63:32] = lane_merge(ext_r[63:32], pwdata, pstrb);
		end
		ext_nxt = ext_nxt & `FCR_DEF_MASK;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ext_r <= `FCR_EXT_RESET;
		end
		else
		begin
			ext_r <= ext_nxt;
		end
	end

	// ****************************************
	// APB answer, one-cycle access phase
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (rd_setup)
			begin
				case (paddr)
					`FCR_ADDR_EXT_LO: prdata <= ext_r[31:0];
					`FCR_ADDR_EXT_HI: prdata <= legacy_mode ? 32'h0000_0000 : ext_r[63:32];
					`FCR_ADDR_CHECK: prdata <= {22'h00_0000, chk_res};
					`FCR_ADDR_STATUS: prdata <= {24'h00_0000, fault_cnt_r};
					default: prdata <= 32'h0000_0000;
				endcase
			end
			else if (!psel)
			begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ****************************************
	// Check request capture
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			req_r <= '0;
			req_valid_r <= 1'b0;
		end
		else
		begin
			req_valid_r <= chk_valid;
			if (chk_valid)
			begin
				req_r <= chk_req;
			end
		end
	end

	// ****************************************
	// Verdict logic
	// ****************************************
	fcr_res_t res_nxt;
	always_comb
	begin
		res_nxt = '0;
		res_nxt.debug_target = req_r.index;
		case (req_r.op)
			FCR_OP_TS_READ, FCR_OP_TS_READ_AUX:
			begin
				res_nxt.priv_fault = ext_r[`FCR_BIT_TSR]
					&& req_r.current_priv_level != 2'h0;
			end
			FCR_OP_PERF_READ:
			begin
				res_nxt.priv_fault = !ext_r[`FCR_BIT_CRD]
					&& req_r.current_priv_level != 2'h0;
				if ({1'b0, req_r.index[1:0]} != req_r.index
					|| req_r.index >= `FCR_PERF_COUNT)
				begin
					res_nxt.undefined_opcode_fault = 1'b1;
				end
			end
			FCR_OP_DBG_ACCESS:
			begin
				if (req_r.index == 3'h4 || req_r.index == 3'h5)
				begin
					if (ext_r[`FCR_BIT_DBG])
					begin
						res_nxt.undefined_opcode_fault = 1'b1;
					end
					else
					begin
						res_nxt.debug_target = req_r.index + 3'h2;
					end
				end
			end
			FCR_OP_MEDIA128:
			begin
				res_nxt.undefined_opcode_fault = !ext_r[`FCR_BIT_OSF];
			end
			FCR_OP_FULL_SAVE:
			begin
				res_nxt.undefined_opcode_fault = 1'b0;
			end
			FCR_OP_SIMD_EXC:
			begin
				res_nxt.undefined_opcode_fault = !ext_r[`FCR_BIT_OSX];
				res_nxt.simd_fp_fault = ext_r[`FCR_BIT_OSX];
			end
			FCR_OP_MC_ERROR:
			begin
				res_nxt.mc_record = 1'b1;
				res_nxt.machine_check_fault = ext_r[`FCR_BIT_MCX] && !req_r.correctable;
			end
			FCR_OP_IRQ_SETCLR:
			begin
				res_nxt.use_virtual_irq = (req_r.v86_mode && ext_r[`FCR_BIT_V86])
					|| (!req_r.v86_mode && ext_r[`FCR_BIT_PMV]);
			end
			FCR_OP_SW_IRQ:
			begin
				res_nxt.redirect_bitmap = req_r.v86_mode && ext_r[`FCR_BIT_V86];
			end
			default:
			begin
				res_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			chk_done <= 1'b0;
			chk_res <= '0;
		end
		else
		begin
			chk_done <= req_valid_r;
			if (req_valid_r)
			begin
				chk_res <= res_nxt;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			fault_cnt_r <= 8'h00;
		end
		else if (req_valid_r && (res_nxt.undefined_opcode_fault || res_nxt.priv_fault
			|| res_nxt.machine_check_fault) && fault_cnt_r != 8'hFF)
		begin
			fault_cnt_r <= fault_cnt_r + 8'h01;
		end
	end

	// ****************************************
	// Translation controls
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			xlate <= '0;
			extension_control <= `FCR_EXT_RESET;
		end
		else
		begin
			extension_control <= legacy_mode ? {32'h0000_0000, ext_r[31:0]} : ext_r;
			xlate.entries_64 <= ext_r[`FCR_BIT_PAX];
			xlate.large_2m <= ext_r[`FCR_BIT_PAX];
			xlate.large_4m <= ext_r[`FCR_BIT_LPG] && !ext_r[`FCR_BIT_PAX];
			xlate.keep_global <= ext_r[`FCR_BIT_GPE];
			xlate.io_breakpoints <= ext_r[`FCR_BIT_DBG];
			xlate.phys_bits <= ext_r[`FCR_BIT_PAX] ? `FCR_PHYS_BITS_EXT
				: `FCR_PHYS_BITS_LEG;
		end
	end

endmodule : fcr_ctrl

// *** fcr_ctrl_sva.sv ***
module fcr_ctrl_sva
	import fcr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Core side
	input wire logic legacy_mode,
	input wire logic chk_valid,
	input wire fcr_req_t chk_req,
	input wire logic chk_done,
	input wire fcr_res_t chk_res,
	input wire fcr_xlate_t xlate,
	input wire logic [63:0] extension_control
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic [63:0] ec;
	assign ec = extension_control;
	// ****************************************
	// Check sequences, register held steady
	// ****************************************
	sequence s_ts;
		chk_valid && chk_req.op == FCR_OP_TS_READ && chk_req.current_priv_level != 2'h0
			&& ec[2] ##1 ec[2] ##1 ec[2];
	endsequence
	sequence s_pc;
		chk_valid && chk_req.op == FCR_OP_PERF_READ && chk_req.current_priv_level != 2'h0
			&& chk_req.index < 3'h4 && !ec[8] ##1 !ec[8] ##1 !ec[8];
	endsequence
	sequence s_dbg;
		chk_valid && chk_req.op == FCR_OP_DBG_ACCESS && chk_req.index == 3'h4 && !ec[3] ##1 !ec[3] ##1 !ec[3];
	endsequence
	AST_RDY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_RSV: assert property (ec[63:11] == 53'h0)
		else $error("reserved bits set");
	AST_LEG: assert property (legacy_mode && psel && penable && pready && paddr == 12'h004 |-> prdata == 32'h0)
		else $error("high word visible in legacy");
	AST_DONE: assert property (chk_valid |-> ##2 chk_done)
		else $error("check answer late");
	AST_ONLY: assert property (chk_done |-> $past(chk_valid, 2))
		else $error("spurious check answer");
	AST_TS_PRIV: assert property (s_ts |-> chk_done && chk_res.priv_fault)
		else $error("timestamp read not refused");
	AST_CTR_PRIV: assert property (s_pc |-> chk_res.priv_fault)
		else $error("counter read not refused");
	AST_DBG: assert property (s_dbg |-> chk_res.debug_target == 3'h6 && !chk_res.undefined_opcode_fault)
		else $error("debug alias wrong");
	AST_ADDR_EXT: assert property (ec[5] |-> xlate.entries_64 && !xlate.large_4m && xlate.phys_bits == 6'h34)
		else $error("address extension controls wrong");
endmodule : fcr_ctrl_sva

bind fcr_ctrl fcr_ctrl_sva u_sva (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr, .legacy_mode, .chk_valid, .chk_req, .chk_done, .chk_res,
	.xlate, .extension_control);

// *** fcr_ctrl_tb.sv ***
module fcr_ctrl_tb
	import fcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, legacy_mode, chk_valid, chk_done, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [63:0] extension_control;
	fcr_req_t chk_req;
	fcr_res_t chk_res, r;
	fcr_xlate_t xlate;
	int err_total, n_compared;
	fcr_ctrl uut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .legacy_mode, .chk_valid, .chk_req, .chk_done, .chk_res, .xlate,
		.extension_control);
	// ****************************************
	// Access tasks
	// ****************************************
	task check(input string nm, input logic [63:0] s, input logic [63:0] e);
		n_compared++;
		if (s !== e)
		begin
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
			err_total++;
		end
	endtask : check
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task run(input logic [31:0] e, input fcr_op_t op, input logic [1:0] pl, input logic [2:0] idx,
		input logic [2:0] fl);
		apb(1'b1, 12'h000, e);
		@(posedge core_clk);
		chk_valid <= 1'b1;
		chk_req <= {fl, pl, idx, op};
		@(posedge core_clk);
		chk_valid <= 1'b0;
		@(posedge core_clk);
		while (chk_done !== 1'b1)
			@(posedge core_clk);
		r = chk_res;
	endtask : run
	task summarize;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial
	begin
		#1000000;
		err_total++;
		summarize();
	end
	initial
	begin
		{rst_b, psel, penable, pwrite, legacy_mode, chk_valid} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		chk_req = '0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		apb(0, 12'h000, 0); check("reset", rd, 0);
		apb(1, 12'h000, 32'hFFFF_FFFF); apb(0, 12'h000, 0); check("low", rd, 32'h7FF);
		apb(1, 12'h004, 32'hFFFF_FFFF); apb(0, 12'h004, 0); check("high", rd, 0);
		apb(0, 12'h010, 0); check("unmapped", er, 1);
		for (int i = 0; i < 11; i++)
		begin
			apb(1, 12'h000, 32'h1 << i); apb(0, 12'h000, 0); check("bit", rd, 32'h1 << i);
		end
		legacy_mode <= 1'b1;
		apb(1, 12'h004, 32'h1); apb(0, 12'h000, 0); check("legacy", rd, 32'h400);
		apb(0, 12'h004, 0); check("legacy hi", rd, 0);
		check("copy", extension_control, 64'h400);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		apb(0, 12'h000, 0); check("reset again", rd, 0);
		legacy_mode <= 1'b0;
		run(32'h004, FCR_OP_TS_READ, 3, 0, 0); check("ts", r.priv_fault, 1);
		run(32'h004, FCR_OP_TS_READ_AUX, 0, 0, 0); check("ts0", r.priv_fault, 0);
		run(0, FCR_OP_TS_READ, 3, 0, 0); check("ts off", r.priv_fault, 0);
		run(0, FCR_OP_PERF_READ, 3, 3, 0); check("pc", r.priv_fault, 1);
		run(32'h100, FCR_OP_PERF_READ, 3, 3, 0); check("pc on", r.priv_fault, 0);
		run(0, FCR_OP_PERF_READ, 0, 4, 0); check("pc idx", r.undefined_opcode_fault, 1);
		run(0, FCR_OP_DBG_ACCESS, 0, 5, 0); check("alias", r.debug_target, 7);
		run(0, FCR_OP_DBG_ACCESS, 0, 4, 0); check("alias4", r.debug_target, 6);
		run(8, FCR_OP_DBG_ACCESS, 0, 4, 0); check("dbg", r.undefined_opcode_fault, 1);
		run(0, FCR_OP_MEDIA128, 0, 0, 0); check("media", r.undefined_opcode_fault, 1);
		run(0, FCR_OP_FULL_SAVE, 0, 0, 0); check("save", r.undefined_opcode_fault, 0);
		run(32'h200, FCR_OP_SIMD_EXC, 0, 0, 0); check("simd", r.undefined_opcode_fault, 1);
		run(32'h600, FCR_OP_SIMD_EXC, 0, 0, 0); check("simd on", r.simd_fp_fault, 1);
		run(32'h040, FCR_OP_MC_ERROR, 0, 0, 0); check("mc", {r.machine_check_fault, r.mc_record}, 3);
		apb(0, 12'h008, 0); check("verdict reg", rd, 32'h120);
		run(32'h040, FCR_OP_MC_ERROR, 0, 0, 1); check("mc c", {r.machine_check_fault, r.mc_record}, 1);
		run(0, FCR_OP_MC_ERROR, 0, 0, 0); check("mc off", {r.machine_check_fault, r.mc_record}, 1);
		run(1, FCR_OP_SW_IRQ, 3, 0, 4); check("v86", {r.use_virtual_irq, r.redirect_bitmap}, 1);
		run(1, FCR_OP_IRQ_SETCLR, 3, 0, 4); check("v86 irq", {r.use_virtual_irq, r.redirect_bitmap}, 2);
		run(2, FCR_OP_SW_IRQ, 3, 0, 4); check("v86 off", {r.use_virtual_irq, r.redirect_bitmap}, 0);
		run(2, FCR_OP_IRQ_SETCLR, 3, 0, 2); check("pvi", {r.use_virtual_irq, r.redirect_bitmap}, 2);
		run(0, FCR_OP_IRQ_SETCLR, 3, 0, 2); check("pvi off", r.use_virtual_irq, 0);
		run(32'h030, FCR_OP_NONE, 0, 0, 2); check("ext", {xlate[10:8], xlate.phys_bits}, {3'h5, 6'h34});
		run(32'h010, FCR_OP_NONE, 0, 0, 0); check("4m", {xlate[9:8], xlate[5:0]}, {2'h2, 6'h20});
		run(32'h080, FCR_OP_NONE, 0, 0, 0); check("global", xlate.keep_global, 1);
		apb(0, 12'h00C, 0); check("faults", rd, 7);
		summarize();
	end
endmodule : fcr_ctrl_tb
